// file: verilog/uepd_pkg.sv
/*
 * Package for the endpoint transfer and DMA control block: command codes,
 * register offsets, field positions, reset values and sizes.
 * Assumes a single controller clock and a plain register port.
 */
// Contract
// - hold loaded packet until start when not auto
// - start carries type; last three endpoint zero
// - refuse start while transmission in progress
// - toggle clear zeroes selected direction, not ep0
// - rx channels to rx, tx to tx
// - three rx, three tx channels, never ep0
// - fixed-map parts ignore channel select writes
// - config write changes only written options
// - no transfer until dma enabled
// - direction selects memory-in or memory-out path
// - single mode irq per packet; multi none
// - auto send when full packet loaded
// - auto acknowledge each received packet
// - host auto in request after fifo empties
// - disable restores normal irqs; direction only
// - dma enabled: only dma and error irqs
// - enable in single mode raises no irq
// - per endpoint bulk packet count held
// - device in underrun when no packet ready
package uepd_pkg;
   localparam int NUM_EP  = 8;
   localparam int EP_W    = 3;
   localparam int NUM_CH  = 3;
   localparam int CH_W    = 2;
   localparam int CNT_W   = 16;

   // register offsets (byte addresses)
   localparam logic [7:0] REG_CMD      = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_CFG      = 8'h08;
   localparam logic [7:0] REG_CHSEL    = 8'h0c;
   localparam logic [7:0] REG_PKTCNT   = 8'h10;
   localparam logic [7:0] REG_EPSEL    = 8'h14;
   localparam logic [7:0] REG_EPSTATE  = 8'h18;

   // command field positions
   localparam int CMD_OP_LSB   = 0;   // 3 bits
   localparam int CMD_TYPE_LSB = 4;   // 3 bits
   localparam int CMD_EP_LSB   = 8;   // 3 bits
   localparam int CMD_DIR_LSB  = 12;  // 1 = transmit (host out / dev in)

   typedef enum logic [2:0] {
      uepd_op_nop     = 3'h0,
      uepd_op_start   = 3'h1,
      uepd_op_tgl_clr = 3'h2,
      uepd_op_dma_en  = 3'h3,
      uepd_op_dma_dis = 3'h4
   } uepd_op_e;

   typedef enum logic [2:0] {
      xfer_type_out      = 3'h0,
      xfer_type_in       = 3'h1,
      xfer_type_in_final = 3'h2,
      xfer_type_setup    = 3'h3,
      xfer_type_status   = 3'h4
   } uepd_xfer_e;

   // config register fields: write mask in [12:8], value in [4:0]
   localparam int CFG_TX     = 0;  // 1 = dir_host_out / dir_dev_in
   localparam int CFG_MULTI  = 1;  // dma_multi_packet_mode
   localparam int CFG_ASEND  = 2;  // auto_send_on_full
   localparam int CFG_AACK   = 3;  // auto_ack_receive
   localparam int CFG_AINREQ = 4;  // auto_in_request
   localparam int CFG_W      = 5;
   localparam int CFG_MASK_LSB = 8;
   localparam logic [CFG_W-1:0] CFG_RST = 5'h00;

   // status bits
   localparam int ST_FAIL    = 0;
   localparam int ST_UNDERRUN = 1;
   localparam int ST_BADCMD  = 2;

   localparam logic [CNT_W-1:0] PKTCNT_RST = 16'h0000;
   localparam logic [CH_W-1:0]  CH_NONE    = 2'h3;
endpackage

// file: verilog/uepd_ctrl.sv
/*
 * Endpoint transfer and DMA control: start commands, toggle clears,
 * per-endpoint DMA config, channel map, packet counts, auto modes.
 * Assumes the packet engine reports fifo levels and transaction events
 * on the same clock; all inputs are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module uepd_ctrl #(
   parameter bit CH_REMAP = 1'b1
) (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rstn,
   // register port
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [31:0]                reg_rdata,
   // role
   input  wire logic                       host_role,
   // packet engine side
   input  wire logic [uepd_pkg::NUM_EP-1:0] tx_pkt_loaded,
   input  wire logic [uepd_pkg::NUM_EP-1:0] tx_busy,
   input  wire logic [uepd_pkg::NUM_EP-1:0] tx_fifo_room,
   input  wire logic [uepd_pkg::NUM_EP-1:0] rx_pkt_ready,
   input  wire logic [uepd_pkg::NUM_EP-1:0] rx_fifo_empty,
   input  wire logic [uepd_pkg::NUM_EP-1:0] pkt_done,
   input  wire logic [uepd_pkg::NUM_EP-1:0] host_in_token,
   input  wire logic [uepd_pkg::NUM_EP-1:0] ep_error,
   output logic                            xfer_start,
   output uepd_pkg::uepd_xfer_e            xfer_type,
   output logic [uepd_pkg::EP_W-1:0]       xfer_ep,
   output logic [uepd_pkg::NUM_EP-1:0]     rx_ack,
   output logic [uepd_pkg::NUM_EP-1:0]     toggle_tx,
   output logic [uepd_pkg::NUM_EP-1:0]     toggle_rx,
   output logic [uepd_pkg::NUM_EP-1:0]     dev_in_no_data_flag,
   // dma side
   output logic [uepd_pkg::NUM_CH-1:0]     dma_tx_req,
   output logic [uepd_pkg::NUM_CH-1:0]     dma_rx_req,
   // interrupt requests to the controller's interrupt logic
   output logic [uepd_pkg::NUM_EP-1:0]     ep_irq
);
   import uepd_pkg::*;

   typedef struct packed {
      logic [NUM_EP-1:0][CFG_W-1:0] cfg;
      logic [NUM_EP-1:0]            dma_en;
      logic [NUM_EP-1:0][CNT_W-1:0] pktcnt;
      logic [NUM_CH-1:0][EP_W-1:0]  tx_map;
      logic [NUM_CH-1:0][EP_W-1:0]  rx_map;
      logic [NUM_EP-1:0]            tgl_tx;
      logic [NUM_EP-1:0]            tgl_rx;
      logic [NUM_EP-1:0]            pend_in;
      logic [NUM_EP-1:0]            underrun;
      logic [2:0]                   status;
      logic [EP_W-1:0]              epsel;
      logic                         start;
      uepd_xfer_e                   stype;
      logic [EP_W-1:0]              sep;
      logic [NUM_EP-1:0]            ack;
      logic [NUM_EP-1:0]            irq;
      logic [NUM_CH-1:0]            txreq;
      logic [NUM_CH-1:0]            rxreq;
      logic [31:0]                  rdata;
   } uepd_state_s;

   uepd_state_s r;
   uepd_state_s next_r;

   // endpoint zero is control only and never joins a dma channel
   function automatic logic ep_ok(input logic [EP_W-1:0] ep);
      return ep != '0;
   endfunction

   function automatic logic type_legal(input uepd_xfer_e t,
                                       input logic [EP_W-1:0] ep,
                                       input logic host);
      case (t)
         xfer_type_out:      return host;
         xfer_type_in:       return !host;
         xfer_type_in_final,
         xfer_type_setup,
         xfer_type_status:   return ep == '0;
         default:            return 1'b0;
      endcase
   endfunction

   logic [EP_W-1:0] c_ep;
   logic            c_tx;
   uepd_op_e        c_op;
   uepd_xfer_e      c_type;
   logic [CFG_W-1:0] c_msk;
   logic [CFG_W-1:0] c_val;
   logic             c_chrx;
   logic [CH_W-1:0]  c_ch;

   assign c_ep   = reg_wdata[CMD_EP_LSB +: EP_W];
   assign c_tx   = reg_wdata[CMD_DIR_LSB];
   assign c_op   = uepd_op_e'(reg_wdata[CMD_OP_LSB +: 3]);
   assign c_type = uepd_xfer_e'(reg_wdata[CMD_TYPE_LSB +: 3]);
   assign c_msk  = reg_wdata[CFG_MASK_LSB +: CFG_W];
   assign c_val  = reg_wdata[CFG_W-1:0];
   assign c_chrx = reg_wdata[CMD_DIR_LSB + 1];
   assign c_ch   = reg_wdata[CMD_TYPE_LSB +: CH_W];

   always_comb begin
      logic auto_go;
      auto_go = 1'b0;
      next_r  = r;
      next_r.start = 1'b0;
      next_r.ack   = '0;
      next_r.irq   = '0;
      next_r.rdata = '0;

      // packet engine events
      for (int e = 0; e < NUM_EP; e++) begin
         // the underrun set wins over a clear in the same cycle
         if (!host_role && host_in_token[e] && !tx_pkt_loaded[e])
            next_r.underrun[e] = 1'b1;
         if (r.cfg[e][CFG_TX]) begin
            // auto send fires only on a full packet and idle endpoint
            if (r.cfg[e][CFG_ASEND] && tx_pkt_loaded[e] && !tx_busy[e]
                && !auto_go && !r.start && ep_ok(EP_W'(e))) begin
               auto_go      = 1'b1;
               next_r.start = 1'b1;
               next_r.sep   = EP_W'(e);
               next_r.stype = host_role ? xfer_type_out : xfer_type_in;
            end
         end else begin
            if (r.cfg[e][CFG_AACK] && rx_pkt_ready[e])
               next_r.ack[e] = 1'b1;
            if (host_role && r.cfg[e][CFG_AINREQ] && r.dma_en[e]
                && rx_fifo_empty[e] && !r.pend_in[e]
                && r.pktcnt[e] != '0) begin
               next_r.pend_in[e] = 1'b1;
               next_r.pktcnt[e]  = r.pktcnt[e] - 1'b1;
            end
         end
         if (pkt_done[e])
            next_r.pend_in[e] = 1'b0;
         // per-packet interrupt only in single mode or without dma
         if (pkt_done[e] && (!r.dma_en[e] || !r.cfg[e][CFG_MULTI]))
            next_r.irq[e] = 1'b1;
         if (ep_error[e])
            next_r.irq[e] = 1'b1;
      end

      // channel requests follow the map and enable
      for (int c = 0; c < NUM_CH; c++) begin
         next_r.txreq[c] = ep_ok(r.tx_map[c]) && r.dma_en[r.tx_map[c]]
            && r.cfg[r.tx_map[c]][CFG_TX]
            && tx_fifo_room[r.tx_map[c]];
         next_r.rxreq[c] = ep_ok(r.rx_map[c]) && r.dma_en[r.rx_map[c]]
            && !r.cfg[r.rx_map[c]][CFG_TX]
            && rx_pkt_ready[r.rx_map[c]];
      end

      if (reg_wr) begin
         if (reg_addr == REG_CMD) begin
            next_r.status[ST_FAIL]   = 1'b0;
            next_r.status[ST_BADCMD] = 1'b0;
            case (c_op)
               uepd_op_start: begin
                  if (tx_busy[c_ep] || (auto_go && next_r.sep == c_ep)) begin
                     next_r.status[ST_FAIL] = 1'b1;
                  end else if (!type_legal(c_type, c_ep, host_role)) begin
                     next_r.status[ST_BADCMD] = 1'b1;
                  end else if (!auto_go) begin
                     next_r.start = 1'b1;
                     next_r.sep   = c_ep;
                     next_r.stype = c_type;
                  end else begin
                     next_r.status[ST_FAIL] = 1'b1;
                  end
               end
               uepd_op_tgl_clr: begin
                  if (!ep_ok(c_ep))
                     next_r.status[ST_BADCMD] = 1'b1;
                  else if (c_tx)
                     next_r.tgl_tx[c_ep] = 1'b0;
                  else
                     next_r.tgl_rx[c_ep] = 1'b0;
               end
               uepd_op_dma_en: begin
                  if (ep_ok(c_ep) && c_tx == r.cfg[c_ep][CFG_TX]) begin
                     next_r.dma_en[c_ep] = 1'b1;
                     // single mode enable stays silent
                     // or-in, so a packet or error pulse is never lost
                     if (r.cfg[c_ep][CFG_MULTI])
                        next_r.irq[c_ep] = 1'b1;
                  end
               end
               uepd_op_dma_dis: begin
                  // only the direction bit matters here
                  if (c_tx == r.cfg[c_ep][CFG_TX])
                     next_r.dma_en[c_ep] = 1'b0;
               end
               default: begin
               end
            endcase
         end else if (reg_addr == REG_STATUS) begin
            next_r.status[ST_FAIL]   = 1'b0;
            next_r.status[ST_BADCMD] = 1'b0;
         end else if (reg_addr == REG_CFG) begin
            for (int b = 0; b < CFG_W; b++)
               if (c_msk[b])
                  next_r.cfg[r.epsel][b] = c_val[b];
         end else if (reg_addr == REG_CHSEL) begin
            // on fixed-map parts the write is simply dropped
            if (CH_REMAP && ep_ok(c_ep) && c_ch < CH_W'(NUM_CH)) begin
               if (c_chrx && !r.cfg[c_ep][CFG_TX])
                  next_r.rx_map[c_ch] = c_ep;
               else if (!c_chrx && r.cfg[c_ep][CFG_TX])
                  next_r.tx_map[c_ch] = c_ep;
            end
         end else if (reg_addr == REG_PKTCNT) begin
            next_r.pktcnt[r.epsel] = reg_wdata[CNT_W-1:0];
         end else if (reg_addr == REG_EPSEL) begin
            next_r.epsel = reg_wdata[EP_W-1:0];
         end else if (reg_addr == REG_EPSTATE) begin
            // write one clears underrun, unless a new one arrives
            for (int e = 0; e < NUM_EP; e++)
               if (reg_wdata[e] && !(!host_role && host_in_token[e]
                                     && !tx_pkt_loaded[e]))
                  next_r.underrun[e] = 1'b0;
         end
      end

      // toggles advance on each completed packet
      for (int e = 0; e < NUM_EP; e++)
         if (pkt_done[e]) begin
            if (r.cfg[e][CFG_TX])
               next_r.tgl_tx[e] = ~r.tgl_tx[e];
            else
               next_r.tgl_rx[e] = ~r.tgl_rx[e];
         end

      if (reg_rd) begin
         if (reg_addr == REG_STATUS)
            next_r.rdata = {29'h0, r.status};
         else if (reg_addr == REG_CFG)
            next_r.rdata = {27'h0, r.cfg[r.epsel]};
         else if (reg_addr == REG_PKTCNT)
            next_r.rdata = {16'h0, r.pktcnt[r.epsel]};
         else if (reg_addr == REG_EPSEL)
            next_r.rdata = {29'h0, r.epsel};
         else if (reg_addr == REG_EPSTATE)
            next_r.rdata = {r.tgl_rx, r.tgl_tx, r.dma_en, r.underrun};
         else if (reg_addr == REG_CHSEL)
            next_r.rdata = {14'h0, r.rx_map, r.tx_map};
         else
            next_r.rdata = '0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         r        <= '0;
         r.stype  <= xfer_type_out;
         for (int c = 0; c < NUM_CH; c++) begin
            // fixed default map: channel c serves endpoint c+1
            r.tx_map[c] <= EP_W'(c + 1);
            r.rx_map[c] <= EP_W'(c + 1);
         end
      end else begin
         r <= next_r;
      end
   end

   assign reg_rdata           = r.rdata;
   assign xfer_start          = r.start;
   assign xfer_type           = r.stype;
   assign xfer_ep             = r.sep;
   assign rx_ack              = r.ack;
   assign toggle_tx           = r.tgl_tx;
   assign toggle_rx           = r.tgl_rx;
   assign dev_in_no_data_flag = r.underrun;
   assign dma_tx_req          = r.txreq;
   assign dma_rx_req          = r.rxreq;
   assign ep_irq              = r.irq;
endmodule
`default_nettype wire

// file: tb/uepd_peer.sv
/*
 * Packet engine and bus peer model for the endpoint control block.
 * Assumes one ref_clk domain; the bench hands in packet loads.
 */
`timescale 1ns/1ps
`default_nettype none
module uepd_peer #(
   parameter int BUSY_CYC = 8
) (
   // clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rstn,
   // transfer requests from the block
   input  wire logic                        xfer_start,
   input  wire logic [uepd_pkg::EP_W-1:0]   xfer_ep,
   // packet loads from the bench
   input  wire logic [uepd_pkg::NUM_EP-1:0] load,
   // engine state back to the block
   output logic      [uepd_pkg::NUM_EP-1:0] tx_pkt_loaded,
   output logic      [uepd_pkg::NUM_EP-1:0] tx_busy,
   output logic      [uepd_pkg::NUM_EP-1:0] pkt_done
);
   import uepd_pkg::*;
   int cnt;
   // one transmission at a time; a start while busy is never honoured
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tx_pkt_loaded <= '0;
         tx_busy <= '0;
         pkt_done <= '0;
         cnt <= 0;
      end else begin
         pkt_done <= '0;
         tx_pkt_loaded <= tx_pkt_loaded | load;
         if (xfer_start && tx_busy == '0) begin
            tx_busy[xfer_ep] <= 1'b1;
            cnt <= BUSY_CYC;
         end else if (cnt == 1) begin
            pkt_done <= tx_busy;
            tx_pkt_loaded <= tx_pkt_loaded & ~tx_busy;
            tx_busy <= '0;
            cnt <= 0;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/uepd_ctrl_monitor.sv
/*
 * Concurrent checks on the ports of the endpoint control block.
 * Assumes a single ref_clk domain with async active-low rstn.
 */
`timescale 1ns/1ps
`default_nettype none
module uepd_ctrl_monitor
   import uepd_pkg::*;
(
   // clock and reset
   input wire logic                ref_clk,
   input wire logic                rstn,
   // register port
   input wire logic [7:0]          reg_addr,
   input wire logic [31:0]         reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata,
   // engine side
   input wire logic                host_role,
   input wire logic [NUM_EP-1:0]   tx_pkt_loaded,
   input wire logic [NUM_EP-1:0]   tx_busy,
   input wire logic [NUM_EP-1:0]   pkt_done,
   input wire logic [NUM_EP-1:0]   host_in_token,
   input wire logic                xfer_start,
   input wire uepd_xfer_e          xfer_type,
   input wire logic [EP_W-1:0]     xfer_ep,
   input wire logic [NUM_EP-1:0]   toggle_tx,
   input wire logic [NUM_EP-1:0]   toggle_rx,
   input wire logic [NUM_EP-1:0]   dev_in_no_data_flag
);
   wire logic            cmd_wr;
   wire logic [2:0]      op;
   wire logic [2:0]      typ;
   wire logic [EP_W-1:0] ep;
   wire logic            legal;
   wire logic [NUM_EP-1:0] starve;
   assign cmd_wr = reg_wr && reg_addr == REG_CMD;
   assign op = reg_wdata[CMD_OP_LSB +: 3];
   assign typ = reg_wdata[CMD_TYPE_LSB +: 3];
   assign ep = reg_wdata[CMD_EP_LSB +: EP_W];
   assign legal = (typ == 3'h0 && host_role) || (typ == 3'h1 && !host_role)
      || (typ >= 3'h2 && typ <= 3'h4 && ep == '0);
   assign starve = host_in_token & ~tx_pkt_loaded;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   start_by_cause_a: assert property (xfer_start |->
      $past(cmd_wr) || $past(|tx_pkt_loaded))
      else $error("start pulse without command or loaded packet");
   start_type_a: assert property (cmd_wr && op == 3'h1 && legal &&
      !tx_busy[ep] && tx_pkt_loaded == '0 |=> xfer_start &&
      xfer_type == $past(typ) && xfer_ep == $past(ep))
      else $error("legal start did not go out as asked");
   bad_type_a: assert property (cmd_wr && op == 3'h1 && !legal &&
      tx_pkt_loaded == '0 |=> !xfer_start)
      else $error("illegal transaction type was started");
   busy_refusal_a: assert property (cmd_wr && op == 3'h1 &&
      tx_busy[ep] |=> !(xfer_start && xfer_ep == $past(ep)))
      else $error("start accepted while endpoint busy");
   status_width_a: assert property (reg_rd &&
      reg_addr == REG_STATUS |=> reg_rdata[31:3] == 29'h0)
      else $error("status read carries stray bits");
   toggle_clear_a: assert property (cmd_wr && op == 3'h2 &&
      ep != '0 && !pkt_done[ep] |=> ($past(reg_wdata[CMD_DIR_LSB]) ?
      toggle_tx[$past(ep)] : toggle_rx[$past(ep)]) == 1'b0)
      else $error("toggle not cleared");
   ep0_toggle_a: assert property (cmd_wr && op == 3'h2 &&
      ep == '0 && !pkt_done[0] |=> $stable(toggle_tx[0]) &&
      $stable(toggle_rx[0]))
      else $error("endpoint zero toggle changed by clear");
   underrun_set_a: assert property (!host_role && starve != '0 |=>
      (dev_in_no_data_flag & $past(starve)) == $past(starve))
      else $error("underrun flag not raised");
   underrun_hold_a: assert property (!(reg_wr &&
      reg_addr == REG_EPSTATE) |=> (dev_in_no_data_flag &
      $past(dev_in_no_data_flag)) == $past(dev_in_no_data_flag))
      else $error("underrun flag dropped without clear");
   cover property (xfer_start);
   cover property (cmd_wr && op == 3'h1 && tx_busy[ep]);
   cover property (cmd_wr && op == 3'h2);
   cover property (dev_in_no_data_flag != '0);
endmodule
bind uepd_ctrl uepd_ctrl_monitor mon (.ref_clk(ref_clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_role(host_role),
   .tx_pkt_loaded(tx_pkt_loaded), .tx_busy(tx_busy), .pkt_done(pkt_done),
   .host_in_token(host_in_token), .xfer_start(xfer_start),
   .xfer_type(xfer_type), .xfer_ep(xfer_ep), .toggle_tx(toggle_tx),
   .toggle_rx(toggle_rx), .dev_in_no_data_flag(dev_in_no_data_flag));
`default_nettype wire

// file: tb/tb_usb_endpoint_dma_transfer_ctrl.sv
/*
 * Self-checking bench for the endpoint control block: start types,
 * refusals, config merge, dma enable, auto send, toggles, underrun.
 * Assumes the peer model drives loaded, busy and done.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_dma_transfer_ctrl;
   import uepd_pkg::*;
   typedef struct packed {
      logic host; logic [2:0] typ; logic [2:0] ep; logic [2:0] st;
   } uepd_row_s;
   // role, type, endpoint, expected status (0 means it starts)
   localparam uepd_row_s ROWS [9] = '{
      '{1'b0, 3'h1, 3'h1, 3'h0}, '{1'b1, 3'h0, 3'h2, 3'h0},
      '{1'b0, 3'h0, 3'h1, 3'h4}, '{1'b1, 3'h1, 3'h1, 3'h4},
      '{1'b0, 3'h2, 3'h0, 3'h0}, '{1'b1, 3'h3, 3'h0, 3'h0},
      '{1'b0, 3'h4, 3'h0, 3'h0}, '{1'b1, 3'h2, 3'h3, 3'h4},
      '{1'b0, 3'h3, 3'h1, 3'h4}};
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic host_role = 1'b0;
   logic [NUM_EP-1:0] load = '0;
   logic [NUM_EP-1:0] tx_fifo_room = '0;
   logic [NUM_EP-1:0] host_in_token = '0;
   logic [NUM_EP-1:0] quiet = '0;
   logic [NUM_EP-1:0] rx_rdy = '0;
   logic [31:0] reg_rdata, d;
   logic xfer_start;
   uepd_xfer_e xfer_type;
   logic [EP_W-1:0] xfer_ep;
   logic [NUM_EP-1:0] loaded, busy, done, rx_ack, tg_tx, tg_rx, flag, irq;
   logic [NUM_CH-1:0] dma_tx_req, dma_rx_req;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   int sa, sb;
   always #5 ref_clk = ~ref_clk;
   uepd_peer peer (.ref_clk(ref_clk), .rstn(rstn), .xfer_start(xfer_start),
      .xfer_ep(xfer_ep), .load(load), .tx_pkt_loaded(loaded),
      .tx_busy(busy), .pkt_done(done));
   uepd_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .host_role(host_role), .tx_pkt_loaded(loaded),
      .tx_busy(busy), .tx_fifo_room(tx_fifo_room), .rx_pkt_ready(rx_rdy),
      .rx_fifo_empty(quiet), .pkt_done(done), .host_in_token(host_in_token),
      .ep_error(quiet), .xfer_start(xfer_start), .xfer_type(xfer_type),
      .xfer_ep(xfer_ep), .rx_ack(rx_ack), .toggle_tx(tg_tx),
      .toggle_rx(tg_rx), .dev_in_no_data_flag(flag),
      .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .ep_irq(irq));
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   function automatic logic [31:0] cmd(input logic [2:0] op, typ, ep,
                                       input logic dir);
      return {19'h0, dir, 1'b0, ep, 1'b0, typ, 1'b0, op};
   endfunction
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      wr(REG_EPSEL, 32'h1);
      rd(REG_CFG); check("cfg reset", d, CFG_RST);
      rd(REG_PKTCNT); check("count reset", d, PKTCNT_RST);
      rd(8'hfc); check("unmapped", d, 32'h0);
      wr(REG_PKTCNT, 32'h5);
      rd(REG_PKTCNT); check("count", d, 32'h5);
      $display("reset test done");
      foreach (ROWS[i]) begin
         host_role <= ROWS[i].host;
         wr(REG_CMD, cmd(3'h1, ROWS[i].typ, ROWS[i].ep, 1'b1));
         #1 check("start", xfer_start, ROWS[i].st == 3'h0);
         if (ROWS[i].st == 3'h0) begin
            check("type", xfer_type, ROWS[i].typ);
            check("ep", xfer_ep, ROWS[i].ep);
         end
         rd(REG_STATUS); check("status", d, ROWS[i].st);
         wr(REG_STATUS, 32'h0);
         repeat (12) @(posedge ref_clk);
      end
      $display("start type table done");
      host_role <= 1'b0;
      wr(REG_CFG, 32'h1f05);
      wr(REG_CFG, 32'h0202);
      rd(REG_CFG); check("cfg merge", d[4:0], 5'h07);
      wr(REG_CMD, cmd(3'h3, 3'h0, 3'h1, 1'b1));
      #1 check("irq multi", irq, 8'h02);
      wr(REG_EPSEL, 32'h2);
      wr(REG_CFG, 32'h1f01);
      wr(REG_CMD, cmd(3'h3, 3'h0, 3'h2, 1'b1));
      #1 check("irq single", irq, 8'h00);
      rd(REG_EPSTATE); check("dma on", d[10], 1'b1);
      tx_fifo_room <= 8'h06;
      repeat (3) @(posedge ref_clk);
      #1 check("tx req", dma_tx_req, 3'h3);
      check("rx req", dma_rx_req, 3'h0);
      // direction mismatch must leave dma on
      wr(REG_CMD, cmd(3'h4, 3'h0, 3'h2, 1'b0));
      rd(REG_EPSTATE); check("dis other dir", d[10], 1'b1);
      wr(REG_CMD, cmd(3'h4, 3'h7, 3'h2, 1'b1));
      rd(REG_EPSTATE); check("dis", d[10], 1'b0);
      repeat (3) @(posedge ref_clk);
      #1 check("req after dis", dma_tx_req, 3'h1);
      tx_fifo_room <= 8'h00;
      $display("dma config test done");
      sa = 0;
      sb = 0;
      load <= 8'h06;
      @(posedge ref_clk);
      load <= 8'h00;
      repeat (12) begin
         @(posedge ref_clk);
         #1 sa += (xfer_start && xfer_ep == 3'h1);
         sb += (xfer_start && xfer_ep == 3'h2);
      end
      check("auto send", sa, 1);
      check("held packet", sb, 0);
      wr(REG_CMD, cmd(3'h1, 3'h1, 3'h2, 1'b1));
      #1 check("manual start", {xfer_start, xfer_ep}, 4'ha);
      wr(REG_CMD, cmd(3'h1, 3'h1, 3'h2, 1'b1));
      #1 check("busy start", xfer_start, 1'b0);
      rd(REG_STATUS); check("busy status", d, 32'h1);
      $display("auto send and busy test done");
      repeat (12) @(posedge ref_clk);
      wr(REG_CMD, cmd(3'h2, 3'h0, 3'h2, 1'b1));
      #1 check("toggle clr", tg_tx[2], 1'b0);
      wr(REG_STATUS, 32'h0);
      wr(REG_CMD, cmd(3'h2, 3'h0, 3'h0, 1'b1));
      rd(REG_STATUS); check("ep0 clear", d, 32'h4);
      host_in_token <= 8'h10;
      @(posedge ref_clk);
      host_in_token <= 8'h00;
      #1 check("underrun", flag, 8'h10);
      wr(REG_EPSEL, 32'h4);
      wr(REG_EPSTATE, 32'h10);
      #1 check("underrun clr", flag[4], 1'b0);
      $display("toggle and underrun test done");
      // endpoint 3 as receive with auto ack, served by rx channel 2
      wr(REG_EPSEL, 32'h3);
      wr(REG_CFG, 32'h0808);
      wr(REG_CMD, cmd(3'h3, 3'h0, 3'h3, 1'b0));
      rx_rdy <= 8'h08;
      @(posedge ref_clk);
      #1 check("auto ack", rx_ack, 8'h08);
      check("rx req on", dma_rx_req, 3'h4);
      rx_rdy <= 8'h00;
      // tx ch2 to ep2 lands; rx ch1 to tx ep2 is refused
      wr(REG_CHSEL, 32'h0220);
      wr(REG_CHSEL, 32'h2210);
      rd(REG_CHSEL); check("chsel", d, 32'h0001a291);
      $display("rx and channel map test done");
      conclude();
   end
endmodule
`default_nettype wire
